// >>> rtl/urc_pkg.sv
// What this block does
// - Feature register bit 7 enables automatic clear-to-send throttling; reset clears it.
// - With throttling on, transmitter stops sending when clear-to-send input reads 1.
// - With throttling on, transmitter restarts sending when clear-to-send input reads 0.
// - Four read/write flow-control character registers, resume and pause pairs, reset zero.
// - Reset: status 0x01, line status 0x60, mode select 0x80, scratchpad 0xff, rest zero except modem status.
// - Reset clears modem status change bits; upper bits show inverted modem input levels.
package urc_pkg;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [3:0] URC_OFS_DATA  = 4'h0;
  localparam logic [3:0] URC_OFS_IER   = 4'h1;
  localparam logic [3:0] URC_OFS_ISR   = 4'h2;
  localparam logic [3:0] URC_OFS_LCR   = 4'h3;
  localparam logic [3:0] URC_OFS_MCR   = 4'h4;
  localparam logic [3:0] URC_OFS_LSR   = 4'h5;
  localparam logic [3:0] URC_OFS_MSR   = 4'h6;
  localparam logic [3:0] URC_OFS_SPR   = 4'h7;
  localparam logic [3:0] URC_OFS_EFR   = 4'h8;
  localparam logic [3:0] URC_OFS_RES1  = 4'h9;
  localparam logic [3:0] URC_OFS_RES2  = 4'ha;
  localparam logic [3:0] URC_OFS_PAU1  = 4'hb;
  localparam logic [3:0] URC_OFS_PAU2  = 4'hc;
  localparam logic [3:0] URC_OFS_ENHANCED_MODE_SELECT_REG  = 4'hd;
  localparam logic [3:0] URC_OFS_FCR   = 4'he;
  localparam logic [3:0] URC_OFS_AFR   = 4'hf;
  // ************************************************************
  // Reset values and fields
  // ************************************************************
  localparam logic [7:0] URC_RST_ZERO  = 8'h00;
  localparam logic [7:0] URC_RST_ISR   = 8'h01;
  localparam logic [7:0] URC_RST_LSR   = 8'h60;
  localparam logic [7:0] URC_RST_ENHANCED_MODE_SELECT_REG  = 8'h80;
  localparam logic [7:0] URC_RST_SPR   = 8'hff;
  localparam int         URC_EFR_ACTS  = 7;
  localparam int         URC_LSR_THRE  = 5;
  localparam int         URC_LSR_TEMT  = 6;
  localparam int         URC_MCR_DTR   = 0;
  localparam int         URC_MCR_RTS   = 1;
  localparam int         URC_MCR_OP1   = 2;
  localparam int         URC_MCR_MF    = 3;
  localparam int         URC_IER_THRE  = 1;
  localparam int         URC_IER_MSI   = 3;
  localparam logic [7:0] URC_ISR_NONE  = 8'h01;
  localparam logic [7:0] URC_ISR_THRE  = 8'h02;
  localparam logic [7:0] URC_ISR_MSI   = 8'h00;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int          URC_CLK_HZ    = 20000000;
  localparam int          URC_BAUD_HZ   = 115200;
  localparam logic [15:0] URC_BIT_TICKS = 16'(URC_CLK_HZ / URC_BAUD_HZ);
  localparam logic [3:0]  URC_FRAME_BITS = 4'ha;
  typedef enum logic [2:0] {
    URC_TX_IDLE = 3'b001,
    URC_TX_WAIT = 3'b010,
    URC_TX_SEND = 3'b100
  } urc_tx_state_t;
endpackage

// >>> rtl/urc_sync.sv
module urc_sync
  import urc_pkg::*;
#(
  parameter int W = 5
)
(
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // Async levels in, filtered levels out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_level;

  // Change counts once second and third stages agree
  always_comb
  begin
    next_level = level_o;
    for (int i = 0; i < W; i++)
    begin
      if (s2[i] == s3[i])
      begin
        next_level[i] = s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      // Keep tracking the pins in reset so no false change follows release
      s1      <= async_i;
      s2      <= s1;
      s3      <= s2;
      level_o <= s3;
    end
    else
    begin
      s1      <= async_i;
      s2      <= s1;
      s3      <= s2;
      level_o <= next_level;
    end
  end
endmodule

// >>> rtl/urc_channel.sv
module urc_channel
  import urc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Modem inputs, active low
  input  wire logic       cts_n_i,
  input  wire logic       dsr_n_i,
  input  wire logic       ri_n_i,
  input  wire logic       cd_n_i,
  // Serial and pin outputs
  output logic            tx_o,
  output logic            rts_n_o,
  output logic            dtr_n_o,
  output logic            user_output_one_n_o,
  output logic            multi_function_out_n_o,
  output logic            transmit_ready_n_o,
  output logic            int_o
);
  // ************************************************************
  // Register state
  // ************************************************************
  logic [7:0] interrupt_enable_reg, next_ier;
  logic [7:0] line_control_reg, next_lcr;
  logic [7:0] modem_control_reg, next_mcr;
  logic [7:0] scratchpad_reg, next_spr;
  logic [7:0] enhanced_feature_reg, next_efr;
  logic [7:0] resume_char_one, next_res1;
  logic [7:0] resume_char_two, next_res2;
  logic [7:0] pause_char_one, next_pau1;
  logic [7:0] pause_char_two, next_pau2;
  logic [7:0] enhanced_mode_select_reg, next_enhanced_mode_select_reg;
  logic [7:0] fifo_control_reg, next_fcr;
  logic [7:0] alternate_function_reg, next_afr;
  logic [7:0] fifo_level_reg;
  logic [7:0] fifo_count_reg;
  logic [3:0] msr_delta, next_delta;
  logic [3:0] msr_prev, next_prev;
  logic       msr_armed, next_armed;
  logic       thre_pend, next_thre_pend;
  logic [7:0] hold_data, next_hold;
  logic       hold_full, next_hold_full;
  logic [7:0] next_rdata;
  logic [3:0] modem_lvl;
  logic       cts_lvl;
  logic [7:0] modem_status_reg;
  logic [7:0] line_status_reg;
  logic [7:0] interrupt_status_reg;
  // ************************************************************
  // Transmitter state
  // ************************************************************
  urc_tx_state_t tx_state, next_tx_state;
  logic [9:0]    shift, next_shift;
  logic [3:0]    bit_cnt, next_bit_cnt;
  logic [15:0]   tick_cnt, next_tick_cnt;
  logic          tick;
  logic          tx_block;

  urc_sync #(
    .W (5)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   ({cts_n_i, dsr_n_i, ri_n_i, cd_n_i, cts_n_i}),
    .level_o   ({cts_lvl, modem_lvl})
  );

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  assign fifo_level_reg   = URC_RST_ZERO;
  assign fifo_count_reg   = URC_RST_ZERO;
  // Upper half: inverted input levels; lower half: change bits
  assign modem_status_reg = {~modem_lvl, msr_delta};
  assign line_status_reg  = {1'b0, ~hold_full & (tx_state == URC_TX_IDLE), ~hold_full,
                             5'h00};
  always_comb
  begin
    if (interrupt_enable_reg[URC_IER_MSI] && (msr_delta != 4'h0))
      interrupt_status_reg = URC_ISR_MSI;
    else if (interrupt_enable_reg[URC_IER_THRE] && thre_pend)
      interrupt_status_reg = URC_ISR_THRE;
    else
      interrupt_status_reg = URC_ISR_NONE;
  end
  // Throttle only takes effect between characters
  assign tx_block = enhanced_feature_reg[URC_EFR_ACTS] & cts_lvl;

  // ************************************************************
  // Register next-state logic
  // ************************************************************
  always_comb
  begin
    next_ier       = interrupt_enable_reg;
    next_lcr       = line_control_reg;
    next_mcr       = modem_control_reg;
    next_spr       = scratchpad_reg;
    next_efr       = enhanced_feature_reg;
    next_res1      = resume_char_one;
    next_res2      = resume_char_two;
    next_pau1      = pause_char_one;
    next_pau2      = pause_char_two;
    next_enhanced_mode_select_reg      = enhanced_mode_select_reg;
    next_fcr       = fifo_control_reg;
    next_afr       = alternate_function_reg;
    next_hold      = hold_data;
    next_hold_full = hold_full;
    next_thre_pend = thre_pend;
    next_prev      = modem_lvl;
    next_armed     = 1'b1;
    next_delta     = msr_delta;
    next_rdata     = 8'h00;
    if (rd_i && hit(addr_i, URC_OFS_MSR))
      next_delta = 4'h0;
    if (rd_i && hit(addr_i, URC_OFS_ISR) && interrupt_status_reg == URC_ISR_THRE)
      next_thre_pend = 1'b0;
    // Set wins over the read clear
    if (msr_armed)
      next_delta = next_delta | (msr_prev ^ modem_lvl);
    if (wr_i)
    begin
      case (addr_i)
        URC_OFS_DATA:
        begin
          next_hold      = wdata_i;
          next_hold_full = 1'b1;
          next_thre_pend = 1'b0;
        end
        URC_OFS_IER:  next_ier  = wdata_i;
        URC_OFS_LCR:  next_lcr  = wdata_i;
        URC_OFS_MCR:  next_mcr  = wdata_i;
        URC_OFS_SPR:  next_spr  = wdata_i;
        URC_OFS_EFR:  next_efr  = wdata_i;
        URC_OFS_RES1: next_res1 = wdata_i;
        URC_OFS_RES2: next_res2 = wdata_i;
        URC_OFS_PAU1: next_pau1 = wdata_i;
        URC_OFS_PAU2: next_pau2 = wdata_i;
        URC_OFS_ENHANCED_MODE_SELECT_REG: next_enhanced_mode_select_reg = wdata_i;
        URC_OFS_FCR:  next_fcr  = wdata_i;
        URC_OFS_AFR:  next_afr  = wdata_i;
        default:      next_afr  = alternate_function_reg;
      endcase
    end
    if (tx_state == URC_TX_IDLE && hold_full && !wr_i)
    begin
      next_hold_full = 1'b0;
      next_thre_pend = 1'b1;
    end
    if (rd_i)
    begin
      case (addr_i)
        URC_OFS_DATA: next_rdata = 8'h00;
        URC_OFS_IER:  next_rdata = interrupt_enable_reg;
        URC_OFS_ISR:  next_rdata = interrupt_status_reg;
        URC_OFS_LCR:  next_rdata = line_control_reg;
        URC_OFS_MCR:  next_rdata = modem_control_reg;
        URC_OFS_LSR:  next_rdata = line_status_reg;
        URC_OFS_MSR:  next_rdata = modem_status_reg;
        URC_OFS_SPR:  next_rdata = scratchpad_reg;
        URC_OFS_EFR:  next_rdata = enhanced_feature_reg;
        URC_OFS_RES1: next_rdata = resume_char_one;
        URC_OFS_RES2: next_rdata = resume_char_two;
        URC_OFS_PAU1: next_rdata = pause_char_one;
        URC_OFS_PAU2: next_rdata = pause_char_two;
        URC_OFS_ENHANCED_MODE_SELECT_REG: next_rdata = enhanced_mode_select_reg;
        URC_OFS_FCR:  next_rdata = fifo_level_reg | fifo_count_reg;
        URC_OFS_AFR:  next_rdata = alternate_function_reg;
        default:      next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      interrupt_enable_reg     <= URC_RST_ZERO;
      line_control_reg         <= URC_RST_ZERO;
      modem_control_reg        <= URC_RST_ZERO;
      scratchpad_reg           <= URC_RST_SPR;
      enhanced_feature_reg     <= URC_RST_ZERO;
      resume_char_one          <= URC_RST_ZERO;
      resume_char_two          <= URC_RST_ZERO;
      pause_char_one           <= URC_RST_ZERO;
      pause_char_two           <= URC_RST_ZERO;
      enhanced_mode_select_reg <= URC_RST_ENHANCED_MODE_SELECT_REG;
      fifo_control_reg         <= URC_RST_ZERO;
      alternate_function_reg   <= URC_RST_ZERO;
      hold_data                <= 8'h00;
      hold_full                <= 1'b0;
      thre_pend                <= 1'b0;
      msr_delta                <= 4'h0;
      msr_prev                 <= 4'hf;
      msr_armed                <= 1'b0;
      rdata_o                  <= 8'h00;
    end
    else
    begin
      interrupt_enable_reg     <= next_ier;
      line_control_reg         <= next_lcr;
      modem_control_reg        <= next_mcr;
      scratchpad_reg           <= next_spr;
      enhanced_feature_reg     <= next_efr;
      resume_char_one          <= next_res1;
      resume_char_two          <= next_res2;
      pause_char_one           <= next_pau1;
      pause_char_two           <= next_pau2;
      enhanced_mode_select_reg <= next_enhanced_mode_select_reg;
      fifo_control_reg         <= next_fcr;
      alternate_function_reg   <= next_afr;
      hold_data                <= next_hold;
      hold_full                <= next_hold_full;
      thre_pend                <= next_thre_pend;
      msr_delta                <= next_delta;
      msr_prev                 <= next_prev;
      msr_armed                <= next_armed;
      rdata_o                  <= next_rdata;
    end
  end

  // ************************************************************
  // Transmitter
  // ************************************************************
  assign tick = (tick_cnt == URC_BIT_TICKS - 16'h0001);

  always_comb
  begin
    next_tx_state = tx_state;
    next_shift    = shift;
    next_bit_cnt  = bit_cnt;
    next_tick_cnt = tick_cnt;
    case (tx_state)
      URC_TX_IDLE:
      begin
        if (hold_full && !wr_i)
        begin
          next_shift    = {1'b1, hold_data, 1'b0};
          next_bit_cnt  = 4'h0;
          next_tick_cnt = 16'h0000;
          next_tx_state = tx_block ? URC_TX_WAIT : URC_TX_SEND;
        end
      end
      URC_TX_WAIT:
      begin
        if (!tx_block)
          next_tx_state = URC_TX_SEND;
      end
      URC_TX_SEND:
      begin
        next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
        if (tick)
        begin
          next_shift   = {1'b1, shift[9:1]};
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == URC_FRAME_BITS - 4'h1)
            next_tx_state = URC_TX_IDLE;
        end
      end
      default: next_tx_state = URC_TX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tx_state <= URC_TX_IDLE;
      shift    <= 10'h3ff;
      bit_cnt  <= 4'h0;
      tick_cnt <= 16'h0000;
    end
    else
    begin
      tx_state <= next_tx_state;
      shift    <= next_shift;
      bit_cnt  <= next_bit_cnt;
      tick_cnt <= next_tick_cnt;
    end
  end

  // ************************************************************
  // Pin outputs
  // ************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tx_o                   <= 1'b1;
      rts_n_o                <= 1'b1;
      dtr_n_o                <= 1'b1;
      user_output_one_n_o    <= 1'b1;
      multi_function_out_n_o <= 1'b1;
      transmit_ready_n_o     <= 1'b0;
      int_o                  <= 1'b0;
    end
    else
    begin
      tx_o                   <= (next_tx_state == URC_TX_SEND) ? next_shift[0] : 1'b1;
      rts_n_o                <= ~next_mcr[URC_MCR_RTS];
      dtr_n_o                <= ~next_mcr[URC_MCR_DTR];
      user_output_one_n_o    <= ~next_mcr[URC_MCR_OP1];
      multi_function_out_n_o <= ~next_mcr[URC_MCR_MF];
      transmit_ready_n_o     <= next_hold_full;
      int_o                  <= (next_ier[URC_IER_THRE] & next_thre_pend) |
                                (next_ier[URC_IER_MSI] & (next_delta != 4'h0));
    end
  end
endmodule

// >>> bench/urc_channel_assertions.sv
module urc_channel_assertions
  import urc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] rdata_o,
  // Pins
  input  wire logic       cts_n_i,
  input  wire logic       tx_o,
  input  wire logic       rts_n_o,
  input  wire logic       dtr_n_o,
  input  wire logic       user_output_one_n_o,
  input  wire logic       multi_function_out_n_o,
  input  wire logic       transmit_ready_n_o,
  input  wire logic       int_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IDLE_RUN = 1800;
  logic        pristine;
  logic        next_pristine;
  logic        acts;
  logic        next_acts;
  logic        pending;
  logic        next_pending;
  logic [11:0] high_run;
  logic [11:0] next_high_run;
  logic [7:0]  chars [4];
  logic [7:0]  next_chars [4];
  logic [7:0]  exp_char;
  logic [7:0]  next_exp_char;
  // ****************************************
  // Shadow of writes, queued byte and idle line time
  // ****************************************
  always_comb
  begin
    next_pristine = pristine && !wr_i;
    next_acts     = (wr_i && addr_i == URC_OFS_EFR) ? wdata_i[URC_EFR_ACTS] : acts;
    next_pending  = (wr_i && addr_i == URC_OFS_DATA) || (pending && tx_o);
    next_high_run = !tx_o ? 12'h000 : ((&high_run) ? high_run : high_run + 12'h001);
    next_chars    = chars;
    next_exp_char = chars[2'(addr_i - URC_OFS_RES1)];
    if (wr_i && addr_i >= URC_OFS_RES1 && addr_i <= URC_OFS_PAU2)
      next_chars[2'(addr_i - URC_OFS_RES1)] = wdata_i;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pristine <= 1'b1;
      acts     <= 1'b0;
      pending  <= 1'b0;
      high_run <= 12'hfff;
      chars    <= '{default: 8'h00};
      exp_char <= 8'h00;
    end
    else
    begin
      pristine <= next_pristine;
      acts     <= next_acts;
      pending  <= next_pending;
      high_run <= next_high_run;
      chars    <= next_chars;
      exp_char <= next_exp_char;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_reset_pins_high: assert property (
    $fell(rst_i) |-> tx_o && rts_n_o && dtr_n_o && user_output_one_n_o && multi_function_out_n_o)
    else $error("Pins not high after reset");
  a_reset_quiet: assert property (
    $fell(rst_i) |-> !int_o && !transmit_ready_n_o)
    else $error("Ready or interrupt not low after reset");
  a_efr_reset: assert property (
    pristine && rd_i && addr_i == URC_OFS_EFR |=> rdata_o == 8'h00)
    else $error("Feature register not clear after reset");
  a_spr_reset: assert property (
    pristine && rd_i && addr_i == URC_OFS_SPR |=> rdata_o == 8'hff)
    else $error("Scratchpad reset value wrong");
  a_isr_reset: assert property (
    pristine && rd_i && addr_i == URC_OFS_ISR |=> rdata_o == 8'h01)
    else $error("Interrupt status reset value wrong");
  a_lsr_reset: assert property (
    pristine && rd_i && addr_i == URC_OFS_LSR |=> rdata_o == 8'h60)
    else $error("Line status reset value wrong");
  a_enhanced_mode_select_reg_reset: assert property (
    pristine && rd_i && addr_i == URC_OFS_ENHANCED_MODE_SELECT_REG |=> rdata_o == 8'h80)
    else $error("Mode select reset value wrong");
  a_flow_chars: assert property (
    rd_i && addr_i >= URC_OFS_RES1 && addr_i <= URC_OFS_PAU2 |=> rdata_o == exp_char)
    else $error("Flow character readback wrong");
  a_cts_hold: assert property (
    cts_n_i [*8] ##0 (acts && high_run >= IDLE_RUN) |=> tx_o)
    else $error("Frame started while clear-to-send inactive");
  a_cts_resume: assert property (
    acts && pending && high_run >= IDLE_RUN && $fell(cts_n_i) |-> ##[1:200] !tx_o)
    else $error("Frame did not resume after clear-to-send");
endmodule

bind urc_channel urc_channel_assertions i_urc_channel_assertions (.sys_clk_i, .rst_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .cts_n_i, .tx_o, .rts_n_o, .dtr_n_o, .user_output_one_n_o,
  .multi_function_out_n_o, .transmit_ready_n_o, .int_o);

// >>> bench/urc_remote_model.sv
module urc_remote_model
  import urc_pkg::*;
(
  // Clock
  input  wire logic       sys_clk_i,
  // Serial line and throttle request
  input  wire logic       tx_i,
  input  wire logic       hold_i,
  // Handshake and received characters
  output logic            cts_n_o,
  output logic      [7:0] rx_byte_o,
  output logic      [7:0] rx_count_o,
  output logic            frame_err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] shift;
  initial
  begin
    cts_n_o     = 1'b0;
    rx_byte_o   = 8'h00;
    rx_count_o  = 8'h00;
    frame_err_o = 1'b0;
  end
  always @(posedge sys_clk_i)
    cts_n_o <= hold_i;
  // Mid-bit sampling: start, eight data bits lsb first, stop
  always
  begin
    @(negedge tx_i);
    repeat (URC_BIT_TICKS / 2) @(posedge sys_clk_i);
    if (tx_i !== 1'b0)
      frame_err_o = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      repeat (URC_BIT_TICKS) @(posedge sys_clk_i);
      shift[i] = tx_i;
    end
    repeat (URC_BIT_TICKS) @(posedge sys_clk_i);
    if (tx_i !== 1'b1)
      frame_err_o = 1'b1;
    rx_byte_o  = shift;
    rx_count_o = rx_count_o + 8'h01;
  end
endmodule

// >>> bench/tb_top.sv
module tb_top
  import urc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk_i;
  logic       rst_i;
  logic       wr_i;
  logic       rd_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic [7:0] rdata_o;
  logic       cts_hold;
  logic       cts_n;
  logic       dsr_n;
  logic       ri_n;
  logic       cd_n;
  logic       tx_o;
  logic       rts_n_o;
  logic       dtr_n_o;
  logic       user_n;
  logic       mf_n;
  logic       transmit_ready_n_n;
  logic       int_o;
  logic [7:0] rx_byte;
  logic [7:0] rx_count;
  logic       frame_err;
  logic [7:0] seen;
  int         miscompares = 0;
  int         checks_done = 0;
  int         cycle_cnt = 0;

  urc_channel i_urc_channel (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ri_n_i(ri_n), .cd_n_i(cd_n), .tx_o, .rts_n_o, .dtr_n_o,
    .user_output_one_n_o(user_n), .multi_function_out_n_o(mf_n), .transmit_ready_n_o(transmit_ready_n_n),
    .int_o);
  urc_remote_model i_urc_remote_model (.sys_clk_i, .tx_i(tx_o), .hold_i(cts_hold),
    .cts_n_o(cts_n), .rx_byte_o(rx_byte), .rx_count_o(rx_count), .frame_err_o(frame_err));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // ****************************************
  // Bus cycles and comparison
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t ns: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 seen = rdata_o;
    chk(seen, exp);
  endtask
  task automatic ichk(input logic e);
    repeat (4) @(posedge sys_clk_i);
    #1 chk(8'(int_o), 8'(e));
  endtask
  task automatic pins;
    chk({1'b0, tx_o, rts_n_o, dtr_n_o, user_n, mf_n, transmit_ready_n_n, int_o}, 8'h7c);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset;
    logic [7:0] e [16];
    e = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'hf0, 8'hff,
          8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
    @(posedge sys_clk_i);
    #1 pins();
    for (int a = 1; a < 16; a++)
      rchk(4'(a), e[a]);
    $display("test_reset done");
  endtask
  task automatic test_regs;
    logic [7:0] v [4];
    v = '{8'ha5, 8'h5a, 8'h3c, 8'hc3};
    for (int i = 0; i < 4; i++)
      wr(4'(9 + i), v[i]);
    wr(4'h5, 8'h00);
    wr(4'h2, 8'hff);
    for (int i = 0; i < 4; i++)
      rchk(4'(9 + i), v[i]);
    rchk(4'h5, 8'h60);
    rchk(4'h2, 8'h01);
    $display("test_regs done");
  endtask
  task automatic test_irq;
    wr(4'h0, 8'h55);
    wr(4'h1, 8'h02);
    ichk(1'b1);
    rchk(4'h2, 8'h02);
    ichk(1'b0);
    wr(4'h1, 8'h00);
    cts_hold <= 1'b1;
    ichk(1'b0);
    wr(4'h1, 8'h08);
    ichk(1'b1);
    rchk(4'h2, 8'h00);
    rchk(4'h6, 8'he1);
    ichk(1'b0);
    wr(4'h1, 8'h00);
    cts_hold <= 1'b0;
    $display("test_irq done");
  endtask
  task automatic test_throttle;
    wr(4'h8, 8'h80);
    cts_hold <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    wr(4'h0, 8'h96);
    repeat (2000) @(posedge sys_clk_i);
    #1 chk({rx_count[6:0], tx_o}, 8'h03);
    chk(rx_byte, 8'h55);
    cts_hold <= 1'b0;
    wait (rx_count === 8'h02);
    chk(rx_byte, 8'h96);
    wr(4'h8, 8'h00);
    cts_hold <= 1'b1;
    wr(4'h0, 8'h69);
    wait (rx_count === 8'h03);
    chk(rx_byte, 8'h69);
    chk(8'(frame_err), 8'h00);
    cts_hold <= 1'b0;
    $display("test_throttle done");
  endtask
  task automatic results;
    $display("Checks: %0d, mismatches: %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge sys_clk_i)
  begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 20000)
    begin
      miscompares++;
      results();
    end
  end
  initial
  begin
    rst_i    = 1'b1;
    wr_i     = 1'b0;
    rd_i     = 1'b0;
    addr_i   = 4'h0;
    wdata_i  = 8'h00;
    cts_hold = 1'b0;
    dsr_n    = 1'b0;
    ri_n     = 1'b0;
    cd_n     = 1'b0;
    repeat (10) @(posedge sys_clk_i);
    #1 pins();
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_regs();
    test_irq();
    test_throttle();
    results();
  end
endmodule
